/* File: hw/hpr_regs.svh */
// What this block does
// - nonremovable mask bit one marks fixed device
// - bits 3..1 map ports, others reserved
// - report nonremovable status of active ports
// - internal default uses fixed device straps
// - self-powered disable mask bit one disables
// - disabled port never enabled nor enumerated
// - any combination; report count, renumber contiguously
// - bus-powered disable mask, same encoding
// - internal default uses port off straps
// - strap nonremovable port forces compound report
// - standard mode renumbers ports above disabled ones
`ifndef HPR_REGS_SVH
`define HPR_REGS_SVH

// ----------------------------------------
// register indices, byte address is index times four
// ----------------------------------------
`define HPR_IDX_NONREM 8'he7
`define HPR_IDX_DIS_SP 8'he8
`define HPR_IDX_DIS_BP 8'he9
`define HPR_IDX_CTRL 8'hf0
`define HPR_IDX_STATUS 8'hf1
`define HPR_IDX_PORTNUM 8'hf2

// ----------------------------------------
// address decode fields
// ----------------------------------------
`define HPR_IDX_LSB 2
`define HPR_IDX_MSB 9
`define HPR_ADDR_HI_LSB 10

// ----------------------------------------
// synchronised pin fields
// ----------------------------------------
`define HPR_PIN_FIXED_LSB 0
`define HPR_PIN_FIXED_MSB 1
`define HPR_PIN_OFF_LSB 2
`define HPR_PIN_OFF_MSB 3
`define HPR_PIN_BUSPWR 4

// ----------------------------------------
// mask fields and reset values
// ----------------------------------------
`define HPR_PORT_LSB 1
`define HPR_PORT_MSB 3
`define HPR_BYTE_MSB 7
`define HPR_MASK_RESET 8'h00
`define HPR_CTRL_RESET 8'h00

// ----------------------------------------
// control bits
// ----------------------------------------
`define HPR_CTRL_STRAP 0
`define HPR_CTRL_RENUM 1
`define HPR_CTRL_COMPOUND 2
`define HPR_CTRL_MSB 2

// ----------------------------------------
// status fields
// ----------------------------------------
`define HPR_ST_ACTIVE_LSB 0
`define HPR_ST_NONREM_LSB 4
`define HPR_ST_COUNT_LSB 8
`define HPR_ST_COMPOUND 12
`define HPR_ST_BUSPWR 13
`define HPR_ST_STRAP 14

// ----------------------------------------
// port number fields
// ----------------------------------------
`define HPR_NUM1_LSB 0
`define HPR_NUM2_LSB 2
`define HPR_NUM3_LSB 4

// ----------------------------------------
// bus encodings
// ----------------------------------------
`define HPR_HSIZE_WORD 3'h2
`define HPR_HRESP_OKAY 1'h0

`endif

/* File: hw/hpr_pkg.sv */
package hpr_pkg;
	// one bit per physical port, bit 0 is port 1
	typedef logic [2:0] hpr_ports_t;
	typedef logic [1:0] hpr_num_t;

	typedef enum logic {
		HPR_PWR_SELF,
		HPR_PWR_BUS
	} hpr_pwr_t;

	typedef enum logic [1:0] {
		HPR_BUS_IDLE,
		HPR_BUS_DATA,
		HPR_BUS_DONE
	} hpr_bus_st_t;

	typedef struct packed {
		hpr_ports_t active;
		hpr_ports_t nonrem;
		hpr_num_t count;
		hpr_num_t num3;
		hpr_num_t num2;
		hpr_num_t num1;
		logic compound;
	} hpr_view_t;

	typedef struct packed {
		logic [7:0] idx;
		logic hit;
		logic write;
		logic word;
	} hpr_req_t;
endpackage : hpr_pkg

/* File: hw/hpr_renum.sv */
`timescale 1ns/1ps
module hpr_renum
	import hpr_pkg::*;
(
	// disabled ports and numbering mode
	input wire hpr_ports_t disabled_in,
	input wire logic renumber_in,
	// numbering seen by the host
	output hpr_num_t num1_out,
	output hpr_num_t num2_out,
	output hpr_num_t num3_out,
	output hpr_num_t count_out
);
	wire hpr_ports_t avail = ~disabled_in;
	wire hpr_num_t below2 = {1'h0, avail[0]};
	wire hpr_num_t below3 = hpr_num_t'({1'h0, avail[0]} + {1'h0, avail[1]});

	// disabled ports get number zero so the host never sees them
	// standard mode closes gaps left by lower disabled ports
	assign num1_out = avail[0] ? 2'h1 : 2'h0;
	assign num2_out = !avail[1] ? 2'h0 : renumber_in ? 2'h2 :
		hpr_num_t'(below2 + 2'h1);
	assign num3_out = !avail[2] ? 2'h0 : renumber_in ? 2'h3 :
		hpr_num_t'(below3 + 2'h1);
	// any combination is legal; the count is what the host is told
	assign count_out = hpr_num_t'(below3 + {1'h0, avail[2]});
endmodule : hpr_renum

/* File: hw/hpr_cfg.sv */
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "hpr_regs.svh"
module hpr_cfg
	import hpr_pkg::*;
(
	// clock, reset, enable
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic ce_in,
	// ahb-lite slave
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	output logic hreadyout_out,
	output logic [31:0] hrdata_out,
	output logic hresp_out,
	// strap and power pins
	input wire logic [1:0] fixed_device_strap_in,
	input wire logic [1:0] port_off_strap_in,
	input wire logic bus_powered_in,
	// port view towards the hub core
	output hpr_ports_t port_active_out,
	output hpr_ports_t port_nonrem_out,
	output hpr_num_t port_count_out,
	output hpr_num_t port1_num_out,
	output hpr_num_t port2_num_out,
	output hpr_num_t port3_num_out,
	output logic compound_out
);

	// ----------------------------------------
	// functions
	// ----------------------------------------

	// strap code n picks physical port n, zero picks none
	function automatic hpr_ports_t strap_to_ports(input logic [1:0] code);
		hpr_ports_t m;
		m = '0;
		if (code != 2'h0) begin
			m[code - 2'h1] = 1'h1;
		end
		return m;
	endfunction : strap_to_ports

	// only bits 3..1 carry ports
	function automatic hpr_ports_t port_field(input logic [7:0] b);
		return b[`HPR_PORT_MSB:`HPR_PORT_LSB];
	endfunction : port_field

	// reserved bits are dropped on write and read back zero
	function automatic logic [7:0] keep_ports(input logic [7:0] b);
		logic [7:0] r;
		r = '0;
		r[`HPR_PORT_MSB:`HPR_PORT_LSB] = b[`HPR_PORT_MSB:`HPR_PORT_LSB];
		return r;
	endfunction : keep_ports

	// byte registers read back in the low byte of the word
	function automatic logic [31:0] reg_word(input logic [7:0] b);
		return {24'h000000, b};
	endfunction : reg_word

	// control bits above the compound select are reserved and read zero
	function automatic logic [7:0] keep_ctrl(input logic [7:0] b);
		logic [7:0] r;
		r = '0;
		r[`HPR_CTRL_MSB:0] = b[`HPR_CTRL_MSB:0];
		return r;
	endfunction : keep_ctrl

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------

	// pins are outside the clock domain; only the second stage is read
	logic [4:0] pin_meta_q;
	logic [4:0] pin_sync_q;

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			pin_meta_q <= '0;
			pin_sync_q <= '0;
		end else if (ce_in) begin
			pin_meta_q <= {bus_powered_in, port_off_strap_in, fixed_device_strap_in};
			pin_sync_q <= pin_meta_q;
		end
	end

	wire logic [1:0] fixed_strap = pin_sync_q[`HPR_PIN_FIXED_MSB:`HPR_PIN_FIXED_LSB];
	wire logic [1:0] off_strap = pin_sync_q[`HPR_PIN_OFF_MSB:`HPR_PIN_OFF_LSB];
	wire hpr_pwr_t pwr_mode = pin_sync_q[`HPR_PIN_BUSPWR] ? HPR_PWR_BUS : HPR_PWR_SELF;

	// ----------------------------------------
	// registers
	// ----------------------------------------

	logic [7:0] nonremovable_port_mask_q;
	logic [7:0] selfpowered_port_disable_mask_q;
	logic [7:0] buspowered_port_disable_mask_q;
	logic [7:0] ctrl_q;

	wire logic use_straps = ctrl_q[`HPR_CTRL_STRAP];
	wire logic renum_sel = ctrl_q[`HPR_CTRL_RENUM];
	wire logic compound_cfg = ctrl_q[`HPR_CTRL_COMPOUND];

	// ----------------------------------------
	// ahb-lite address phase
	// ----------------------------------------

	hpr_bus_st_t bus_q;
	hpr_bus_st_t bus_d;
	hpr_req_t req_q;
	hpr_req_t req_d;

	// a new address phase is only taken while the bus says ready
	wire logic take = hsel_in && htrans_in[1] && hready_in;
	wire logic addr_hi_zero = (haddr_in[31:`HPR_ADDR_HI_LSB] == '0);
	wire logic addr_aligned = (haddr_in[1:0] == 2'h0);

	always_comb begin
		req_d.idx = haddr_in[`HPR_IDX_MSB:`HPR_IDX_LSB];
		req_d.hit = addr_hi_zero && addr_aligned;
		req_d.write = hwrite_in;
		req_d.word = (hsize_in == `HPR_HSIZE_WORD);
	end

	// ----------------------------------------
	// data phase decode
	// ----------------------------------------

	// one wait state: read data is built after earlier writes settle
	wire logic in_data = (bus_q == HPR_BUS_DATA);
	wire logic wr_ok = in_data && req_q.hit && req_q.write && req_q.word;
	wire logic wr_nonrem = wr_ok && (req_q.idx == `HPR_IDX_NONREM);
	wire logic wr_dis_sp = wr_ok && (req_q.idx == `HPR_IDX_DIS_SP);
	wire logic wr_dis_bp = wr_ok && (req_q.idx == `HPR_IDX_DIS_BP);
	wire logic wr_ctrl = wr_ok && (req_q.idx == `HPR_IDX_CTRL);
	wire logic rd_ok = in_data && req_q.hit && !req_q.write;

	always_comb begin
		bus_d = bus_q;
		unique case (bus_q)
			HPR_BUS_IDLE: begin
				if (take) begin
					bus_d = HPR_BUS_DATA;
				end
			end
			HPR_BUS_DATA: begin
				bus_d = HPR_BUS_DONE;
			end
			HPR_BUS_DONE: begin
				bus_d = take ? HPR_BUS_DATA : HPR_BUS_IDLE;
			end
		endcase
	end

	// ----------------------------------------
	// effective port masks
	// ----------------------------------------

	// straps stand in for the mask bytes under the internal default
	wire hpr_ports_t nonrem_src = use_straps ? strap_to_ports(fixed_strap) :
		port_field(nonremovable_port_mask_q);

	// one mask per powering mode
	wire hpr_ports_t dis_mask = (pwr_mode == HPR_PWR_BUS) ?
		port_field(buspowered_port_disable_mask_q) :
		port_field(selfpowered_port_disable_mask_q);

	// a one disables the port, a zero leaves it available
	wire hpr_ports_t dis_src = use_straps ? strap_to_ports(off_strap) : dis_mask;
	wire hpr_ports_t active = ~dis_src;

	// the hub reports nonremovable only for active ports
	wire hpr_ports_t nonrem_rep = nonrem_src & active;

	// strap setup with any fixed device implies a compound hub
	wire logic compound = use_straps ? (nonrem_src != '0) : compound_cfg;

	hpr_num_t num1;
	hpr_num_t num2;
	hpr_num_t num3;
	hpr_num_t count;

	hpr_renum u_renum (
		.disabled_in(dis_src),
		.renumber_in(renum_sel),
		.num1_out(num1),
		.num2_out(num2),
		.num3_out(num3),
		.count_out(count)
	);

	// ----------------------------------------
	// read data
	// ----------------------------------------

	// status fields sit at fixed positions so software can mask them
	logic [31:0] status_word;
	logic [31:0] num_word;

	always_comb begin
		status_word = '0;
		status_word[`HPR_ST_ACTIVE_LSB +: $bits(hpr_ports_t)] = active;
		status_word[`HPR_ST_NONREM_LSB +: $bits(hpr_ports_t)] = nonrem_rep;
		status_word[`HPR_ST_COUNT_LSB +: $bits(hpr_num_t)] = count;
		status_word[`HPR_ST_COMPOUND] = compound;
		status_word[`HPR_ST_BUSPWR] = (pwr_mode == HPR_PWR_BUS);
		status_word[`HPR_ST_STRAP] = use_straps;
	end

	always_comb begin
		num_word = '0;
		num_word[`HPR_NUM1_LSB +: $bits(hpr_num_t)] = num1;
		num_word[`HPR_NUM2_LSB +: $bits(hpr_num_t)] = num2;
		num_word[`HPR_NUM3_LSB +: $bits(hpr_num_t)] = num3;
	end

	logic [31:0] rd_word;

	always_comb begin
		rd_word = '0;
		if (rd_ok) begin
			unique case (req_q.idx)
				`HPR_IDX_NONREM: rd_word = reg_word(nonremovable_port_mask_q);
				`HPR_IDX_DIS_SP: rd_word = reg_word(selfpowered_port_disable_mask_q);
				`HPR_IDX_DIS_BP: rd_word = reg_word(buspowered_port_disable_mask_q);
				`HPR_IDX_CTRL: rd_word = reg_word(ctrl_q);
				`HPR_IDX_STATUS: rd_word = status_word;
				`HPR_IDX_PORTNUM: rd_word = num_word;
				default: rd_word = '0;
			endcase
		end
	end

	// ----------------------------------------
	// bus flops
	// ----------------------------------------

	// state and the captured address phase
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			bus_q <= HPR_BUS_IDLE;
			req_q <= '0;
		end else if (ce_in) begin
			bus_q <= bus_d;
			if (bus_d == HPR_BUS_DATA) begin
				req_q <= req_d;
			end
		end
	end

	// ready drops for the single wait state only
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			hreadyout_out <= 1'h1;
		end else if (ce_in) begin
			hreadyout_out <= (bus_d != HPR_BUS_DATA);
		end
	end

	// read data stands until the next data phase
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			hrdata_out <= '0;
		end else if (ce_in && in_data) begin
			hrdata_out <= rd_word;
		end
	end

	// refused accesses are dropped quietly, so no error response exists
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			hresp_out <= `HPR_HRESP_OKAY;
		end else if (ce_in) begin
			hresp_out <= `HPR_HRESP_OKAY;
		end
	end

	// ----------------------------------------
	// register writes
	// ----------------------------------------

	// bits 3..1 of the fixed device mask are left to firmware
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			nonremovable_port_mask_q <= `HPR_MASK_RESET;
		end else if (ce_in && wr_nonrem) begin
			nonremovable_port_mask_q <= keep_ports(hwdata_in[`HPR_BYTE_MSB:0]);
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			selfpowered_port_disable_mask_q <= `HPR_MASK_RESET;
		end else if (ce_in && wr_dis_sp) begin
			selfpowered_port_disable_mask_q <= keep_ports(hwdata_in[`HPR_BYTE_MSB:0]);
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			buspowered_port_disable_mask_q <= `HPR_MASK_RESET;
		end else if (ce_in && wr_dis_bp) begin
			buspowered_port_disable_mask_q <= keep_ports(hwdata_in[`HPR_BYTE_MSB:0]);
		end
	end

	// reserved control bits are not stored
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ctrl_q <= `HPR_CTRL_RESET;
		end else if (ce_in && wr_ctrl) begin
			ctrl_q <= keep_ctrl(hwdata_in[`HPR_BYTE_MSB:0]);
		end
	end

	// ----------------------------------------
	// port view outputs
	// ----------------------------------------

	// disabled ports drop out of the view for as long as the mask holds
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			port_active_out <= '0;
			port_nonrem_out <= '0;
			port_count_out <= '0;
			port1_num_out <= '0;
			port2_num_out <= '0;
			port3_num_out <= '0;
			compound_out <= 1'h0;
		end else if (ce_in) begin
			port_active_out <= active;
			port_nonrem_out <= nonrem_rep;
			port_count_out <= count;
			port1_num_out <= num1;
			port2_num_out <= num2;
			port3_num_out <= num3;
			compound_out <= compound;
		end
	end
endmodule : hpr_cfg

/* File: sim/hpr_host_model.sv */
`timescale 1ns/1ps
module hpr_host_model
	import hpr_pkg::*;
(
	// port view from the hub
	input wire hpr_ports_t active_in,
	input wire hpr_num_t num1_in,
	input wire hpr_num_t num2_in,
	input wire hpr_num_t num3_in,
	// host port numbers enumerated
	output logic [3:0] seen_out
);
	// ----------------
	// enumeration
	// ----------------
	// fixed devices answer with their own descriptors, none kept here
	wire logic [3:0] s1 = active_in[0] ? (4'h1 << num1_in) : 4'h0;
	wire logic [3:0] s2 = active_in[1] ? (4'h1 << num2_in) : 4'h0;
	wire logic [3:0] s3 = active_in[2] ? (4'h1 << num3_in) : 4'h0;
	// number 0 is never enabled by the host
	assign seen_out = (s1 | s2 | s3) & 4'he;
endmodule : hpr_host_model

/* File: sim/hpr_cfg_sva.sv */
`timescale 1ns/1ps
module hpr_cfg_sva
	import hpr_pkg::*;
(
	// bus side
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic ce_in,
	input wire logic hsel_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic hready_in,
	input wire logic hreadyout_out,
	input wire logic [31:0] hrdata_out,
	input wire logic hresp_out,
	// port view
	input wire hpr_ports_t port_active_out,
	input wire hpr_ports_t port_nonrem_out,
	input wire hpr_num_t port_count_out,
	input wire hpr_num_t port1_num_out,
	input wire hpr_num_t port2_num_out,
	input wire hpr_num_t port3_num_out,
	input wire logic compound_out
);
	// ----------------
	// checks
	// ----------------
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	wire tk = hsel_in && htrans_in[1] && hready_in && hreadyout_out && ce_in;
	wire [2:0] a = port_active_out;
	property p_okay; hresp_out == 1'h0; endproperty
	a_okay: assert property (p_okay) else $error("hresp not okay");
	property p_wait; tk |=> !hreadyout_out ##1 hreadyout_out; endproperty
	a_wait: assert property (p_wait) else $error("wait state wrong");
	// read data only moves when a data phase ends
	property p_hold; $changed(hrdata_out) |-> $rose(hreadyout_out); endproperty
	a_hold: assert property (p_hold) else $error("hrdata moved");
	property p_nonrem; (port_nonrem_out & ~a) == 3'h0; endproperty
	a_nonrem: assert property (p_nonrem) else $error("nonrem on hidden port");
	property p_count; port_count_out == $countones(a); endproperty
	a_count: assert property (p_count) else $error("port count wrong");
	property p_hide;
		(a[0] || port1_num_out == 2'h0) && (a[1] || port2_num_out == 2'h0)
			&& (a[2] || port3_num_out == 2'h0);
	endproperty
	a_hide: assert property (p_hide) else $error("disabled port numbered");
	property p_shown;
		(!a[0] || port1_num_out != 2'h0) && (!a[1] || port2_num_out != 2'h0)
			&& (!a[2] || port3_num_out != 2'h0);
	endproperty
	a_shown: assert property (p_shown) else $error("active port unnumbered");
	property p_dist;
		!(a[0] && a[1] && port1_num_out == port2_num_out)
			&& !(a[1] && a[2] && port2_num_out == port3_num_out)
			&& !(a[0] && a[2] && port1_num_out == port3_num_out);
	endproperty
	a_dist: assert property (p_dist) else $error("port numbers clash");
	c_wr: cover property (tk && hwrite_in);
	c_rd: cover property (tk && !hwrite_in);
	c_none: cover property (port_count_out == 2'h0);
	c_comp: cover property (compound_out);
endmodule : hpr_cfg_sva

bind hpr_cfg hpr_cfg_sva hpr_cfg_sva_inst (.*);

/* File: sim/tb_hpr_cfg.sv */
`timescale 1ns/1ps
`include "hpr_regs.svh"
module tb_hpr_cfg
	import hpr_pkg::*;
;
	// ----------------
	// harness
	// ----------------
	logic clk_in = 1'h0, rstn_in = 1'h0, ce_in = 1'h1, hsel_in = 1'h0, hwrite_in = 1'h0;
	logic bus_powered_in = 1'h0;
	logic [1:0] htrans_in = 2'h0, fixed_device_strap_in = 2'h0, port_off_strap_in = 2'h0;
	logic [2:0] hsize_in = `HPR_HSIZE_WORD;
	logic [31:0] haddr_in = 32'h0, hwdata_in = 32'h0;
	wire hready_in, hreadyout_out, hresp_out, compound_out;
	wire [31:0] hrdata_out;
	wire [3:0] seen;
	hpr_ports_t port_active_out, port_nonrem_out;
	hpr_num_t port_count_out, port1_num_out, port2_num_out, port3_num_out;
	int fails = 0, checks_done = 0;
	assign hready_in = hreadyout_out;
	hpr_cfg hpr_cfg_inst (.*);
	hpr_host_model hpr_host_model_inst (.active_in(port_active_out), .num1_in(port1_num_out),
		.num2_in(port2_num_out), .num3_in(port3_num_out), .seen_out(seen));
	initial forever #12.5 clk_in = ~clk_in;
	task complete_run;
		$display("fails %0d checks_done %0d", fails, checks_done);
		if (fails == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : complete_run
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	// no open-ended waits: a stuck slave ends the run
	task automatic wt;
		int n;
		n = 0;
		do begin @(posedge clk_in); n++; end while (hreadyout_out !== 1'h1 && n < 20);
		if (hreadyout_out !== 1'h1) begin
			fails++;
			complete_run();
		end
	endtask : wt
	task automatic xfer(input logic w, input logic [7:0] i, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge clk_in);
		hsel_in <= 1'h1;
		htrans_in <= 2'h2;
		hwrite_in <= w;
		haddr_in <= {22'h0, i, 2'h0};
		wt();
		htrans_in <= 2'h0;
		hwdata_in <= d;
		wt();
		r = hrdata_out;
	endtask : xfer
	task automatic wr(input logic [7:0] i, input logic [31:0] d);
		logic [31:0] r;
		xfer(1'h1, i, d, r);
	endtask : wr
	task automatic rd(input logic [7:0] i, input logic [31:0] e);
		logic [31:0] r;
		xfer(1'h0, i, 32'h0, r);
		chk(r, e);
	endtask : rd
	task automatic cv(input logic [2:0] ac, input logic [2:0] nr, input logic [1:0] c,
		input logic [1:0] p1, input logic [1:0] p2, input logic [1:0] p3, input logic cp);
		@(negedge clk_in);
		chk({port_active_out, port_nonrem_out, port_count_out, port1_num_out, port2_num_out,
			port3_num_out, compound_out}, {ac, nr, c, p1, p2, p3, cp});
	endtask : cv
	task automatic pins(input logic bp, input logic [1:0] fd, input logic [1:0] po);
		@(posedge clk_in);
		bus_powered_in <= bp;
		fixed_device_strap_in <= fd;
		port_off_strap_in <= po;
		repeat (4) @(posedge clk_in);
	endtask : pins
	initial begin
		repeat (2) @(posedge clk_in);
		rstn_in <= 1'h1;
		rd(`HPR_IDX_NONREM, 32'h0);
		rd(`HPR_IDX_DIS_SP, 32'h0);
		rd(`HPR_IDX_DIS_BP, 32'h0);
		rd(`HPR_IDX_STATUS, 32'h307);
		rd(`HPR_IDX_PORTNUM, 32'h39);
		wr(`HPR_IDX_NONREM, 32'hf3);
		rd(`HPR_IDX_NONREM, 32'h2);
		cv(3'h7, 3'h1, 2'h3, 2'h1, 2'h2, 2'h3, 1'h0);
		wr(`HPR_IDX_DIS_SP, 32'h4);
		cv(3'h5, 3'h1, 2'h2, 2'h1, 2'h0, 2'h2, 1'h0);
		chk(seen, 4'h6);
		wr(`HPR_IDX_DIS_BP, 32'ha);
		cv(3'h5, 3'h1, 2'h2, 2'h1, 2'h0, 2'h2, 1'h0);
		pins(1'h1, 2'h0, 2'h0);
		cv(3'h2, 3'h0, 2'h1, 2'h0, 2'h1, 2'h0, 1'h0);
		rd(`HPR_IDX_STATUS, 32'h2102);
		wr(`HPR_IDX_DIS_BP, 32'he);
		cv(3'h0, 3'h0, 2'h0, 2'h0, 2'h0, 2'h0, 1'h0);
		// physical numbers kept, compound from control
		wr(`HPR_IDX_DIS_BP, 32'h2);
		wr(`HPR_IDX_CTRL, 32'h6);
		cv(3'h6, 3'h0, 2'h2, 2'h0, 2'h2, 2'h3, 1'h0 | 1'h1);
		rd(`HPR_IDX_PORTNUM, 32'h38);
		wr(`HPR_IDX_CTRL, 32'h1);
		cv(3'h7, 3'h0, 2'h3, 2'h1, 2'h2, 2'h3, 1'h0);
		// clock enable low freezes the view although the pins move
		@(posedge clk_in);
		ce_in <= 1'h0;
		pins(1'h1, 2'h2, 2'h3);
		cv(3'h7, 3'h0, 2'h3, 2'h1, 2'h2, 2'h3, 1'h0);
		@(posedge clk_in);
		ce_in <= 1'h1;
		pins(1'h1, 2'h2, 2'h3);
		cv(3'h3, 3'h2, 2'h2, 2'h1, 2'h2, 2'h0, 1'h1);
		rd(`HPR_IDX_STATUS, 32'h7223);
		chk(seen, 4'h6);
		wr(8'h10, 32'hff);
		rd(8'h10, 32'h0);
		complete_run();
	end
endmodule : tb_hpr_cfg
